// ### dv/dual_encoder_count_front_end_test.sv
// self-checking bench for the dual encoder front end
module dual_encoder_count_front_end_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk = 1'b0;
	logic        sys_rst;
	logic [7:0]  addr;
	logic [31:0] wr_data;
	logic        wr_en;
	logic        rd_en;
	logic [31:0] rd_data;
	logic [3:0]  enc1_pins;
	logic [3:0]  enc2_pins;
	logic [1:0]  ext_preset;
	logic        power_restore;
	logic [31:0] count1;
	logic [31:0] count2;
	int          err_total = 0;
	int          check_count = 0;
	int          cyc = 0;

	always #50 mclk = ~mclk;

	dual_encoder_count_front_end i_dut (.mclk, .sys_rst, .addr, .wr_data,
		.wr_en, .rd_en, .rd_data, .enc1_pins, .enc2_pins, .ext_preset,
		.power_restore, .count1, .count2);
	enc_model i_enc1 (.mclk, .pins(enc1_pins));
	enc_model i_enc2 (.mclk, .pins(enc2_pins));

	// ----------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// a strobe still high from a previous write costs one idle cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		if (wr_en)
			@(posedge mclk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask

	task automatic rchk(input string what, input logic [7:0] a,
		input logic [31:0] exp);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1 chk(what, rd_data, exp);
		@(posedge mclk);
	endtask

	// compare once the count has been quiet for 32 cycles
	task automatic wait_cnt(input bit ch, input logic [31:0] exp,
		input string what);
		int quiet;
		logic [31:0] v;
		logic [31:0] last;
		quiet = 0;
		last = 32'h0;
		for (int i = 0; i < 800 && quiet < 32; i++) begin
			@(posedge mclk);
			#1 v = ch ? count2 : count1;
			quiet = (v === last) ? quiet + 1 : 0;
			last = v;
		end
		chk(what, v, exp);
		@(posedge mclk);
	endtask

	task automatic pulse(input bit pw, input logic [1:0] ep);
		power_restore <= pw;
		ext_preset <= ep;
		@(posedge mclk);
		power_restore <= 1'b0;
		ext_preset <= 2'b00;
	endtask

	// ----------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------
	task automatic t_reset_vals();
		logic [7:0] g;
		for (int c = 0; c < 2; c++) begin
			g = 8'(c * 16);
			rchk("signal type", g, 32'h1);
			rchk("edge res", g + 8'h1, 32'h0);
			rchk("sense", g + 8'h2, 32'h0);
			rchk("scale", g + 8'h3, 32'h000186a0);
			rchk("repeat", g + 8'h4, 32'h1);
			rchk("wrap", g + 8'h5, 32'h0);
			rchk("preset", g + 8'h6, 32'h0);
		end
		rchk("retention", 8'h21, 32'h0);
		rchk("unmapped", 8'h3f, 32'h0);
		rchk("command", 8'h22, 32'h0);
		$display("test reset_vals done");
	endtask

	task automatic t_quad();
		logic [31:0] e;
		for (int r = 0; r < 3; r++) begin
			for (int s = 0; s < 2; s++) begin
				e = 32'(2 << r);
				// single-ended quadrature first, then differential
				wr(8'h00, 32'(s ^ 1));
				wr(8'h01, 32'(r));
				wr(8'h02, 32'(s));
				wr(8'h22, 32'h1);
				wait_cnt(0, 32'h0, "preset cmd");
				i_enc1.quad(2, 1'b1, 4);
				wait_cnt(0, s ? -e : e, "quad");
			end
		end
		i_enc1.quad(1, 1'b0, 4);
		wait_cnt(0, 32'hfffffffc, "b leads a");
		rchk("count reg", 8'h07, 32'hfffffffc);
		$display("test quad done");
	endtask

	task automatic t_cdir();
		wr(8'h10, 32'h3);
		i_enc2.cdir(3, 1'b1, 4);
		wait_cnt(1, 32'hfffffffd, "b high down");
		wr(8'h10, 32'h2);
		wr(8'h11, 32'h1);
		i_enc2.cdir(3, 1'b0, 3);
		wait_cnt(1, 32'h3, "b low up x2");
		chk("ch1 untouched", count1, 32'hfffffffc);
		$display("test cdir done");
	endtask

	task automatic t_scale();
		wr(8'h01, 32'h0);
		wr(8'h02, 32'h0);
		wr(8'h03, 32'd40000);
		wr(8'h04, 32'h3);
		rchk("repeat back", 8'h04, 32'h3);
		wr(8'h22, 32'h1);
		wait_cnt(0, 32'h0, "preset cmd");
		i_enc1.quad(4, 1'b1, 2);
		wait_cnt(0, 32'h4, "scaled 4.8");
		i_enc1.quad(1, 1'b1, 6);
		wait_cnt(0, 32'h6, "remainder");
		wr(8'h03, 32'h000186a0);
		wr(8'h04, 32'h1);
		$display("test scale done");
	endtask

	task automatic t_wrap();
		wr(8'h06, 32'h4);
		wr(8'h05, 32'h5);
		wr(8'h22, 32'h1);
		wait_cnt(0, 32'h4, "preset value");
		i_enc1.quad(3, 1'b1, 4);
		wait_cnt(0, 32'h1, "wrap up");
		i_enc1.quad(3, 1'b0, 4);
		wait_cnt(0, 32'h4, "wrap down");
		$display("test wrap done");
	endtask

	task automatic t_power();
		wr(8'h16, 32'h7);
		pulse(1'b0, 2'b10);
		wait_cnt(1, 32'h7, "ext preset");
		pulse(1'b1, 2'b00);
		wait_cnt(1, 32'h0, "ch2 cleared");
		chk("ch1 cleared", count1, 32'h0);
		wr(8'h21, 32'h1);
		pulse(1'b0, 2'b01);
		wait_cnt(0, 32'h4, "ext preset");
		pulse(1'b1, 2'b00);
		wait_cnt(0, 32'h4, "retained");
		$display("test power done");
	endtask

	initial begin
		sys_rst = 1'b1;
		addr = 8'h0;
		wr_data = 32'h0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		ext_preset = 2'b00;
		power_restore = 1'b0;
		repeat (5) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		t_reset_vals();
		t_quad();
		t_cdir();
		t_scale();
		t_wrap();
		t_power();
		close_out();
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			$display("timeout after %0d cycles", cyc);
			close_out();
		end
	end
endmodule

// ### dv/enc_front_sva.sv
// port assertions for the dual encoder front end
module enc_front_sva (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// register port
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wr_data,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	input  wire logic [31:0] rd_data,
	// encoder pins and controls
	input  wire logic [3:0]  enc1_pins,
	input  wire logic [3:0]  enc2_pins,
	input  wire logic [1:0]  ext_preset,
	input  wire logic        power_restore,
	// counter values
	input  wire logic [31:0] count1,
	input  wire logic [31:0] count2
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] pre1;
	logic [31:0] wrap1;
	logic        ret;

	// ----------------------------------------------------------
	// shadow copies of channel 1 preset, wrap and retention
	// ----------------------------------------------------------
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pre1 <= 32'h0;
			wrap1 <= 32'h0;
			ret <= 1'b0;
		end else if (wr_en) begin
			if (addr == 8'h06)
				pre1 <= wr_data;
			if (addr == 8'h05)
				wrap1 <= wr_data;
			if (addr == 8'h21)
				ret <= wr_data[0];
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence s_wr_rep;
		wr_en && addr == 8'h04 && wr_data[7:0] != 8'h0;
	endsequence
	sequence s_rd_rep;
		rd_en && addr == 8'h04;
	endsequence

	a_rd_idle_zero: assert property (!$past(rd_en) |-> rd_data == 32'h0)
		else $error("read data not zero outside read");
	a_cmd_reads_zero: assert property (
		rd_en && addr == 8'h22 |=> rd_data == 32'h0)
		else $error("command register read not zero");
	a_unmapped_zero: assert property (
		rd_en && addr[7:4] > 4'h2 |=> rd_data == 32'h0)
		else $error("unmapped read not zero");
	a_count_readout: assert property (
		rd_en && addr == 8'h07 |=> rd_data == $past(count1))
		else $error("count register differs from count1");
	a_repeat_readback: assert property (
		s_wr_rep ##1 s_rd_rep |=>
		rd_data == {24'h0, $past(wr_data[7:0], 2)})
		else $error("repeat factor readback wrong");
	a_preset_load: assert property (
		ext_preset[0] |=> count1 == pre1)
		else $error("external preset not loaded");
	a_cmd_preset: assert property (
		wr_en && addr == 8'h22 && wr_data[0] |=> count1 == pre1)
		else $error("command preset not loaded");
	a_power_clear: assert property (
		power_restore && !ret && !ext_preset[0] |=> count1 == 32'h0)
		else $error("count not cleared on power return");
	a_step_by_one: assert property (
		$changed(count1) && !$past(ext_preset[0]) && !$past(power_restore)
		&& !$past(wr_en) && !$past(wr_en, 2) |->
		count1 == $past(count1) + 32'h1 || count1 == $past(count1) - 32'h1
		|| count1 == 32'h0 || count1 == wrap1)
		else $error("count1 jumped by more than one");
endmodule

bind dual_encoder_count_front_end enc_front_sva i_sva (
	.mclk, .sys_rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
	.enc1_pins, .enc2_pins, .ext_preset, .power_restore,
	.count1, .count2
);

// ### dv/enc_model.sv
// incremental encoder or count/direction sensor for one input channel
module enc_model (
	// clock
	input  wire logic  mclk,
	// encoder pins: a, /a, b, /b
	output logic [3:0] pins
);
	timeunit 1ns;
	timeprecision 1ns;
	int ph;

	initial begin
		ph = 0;
		pins = 4'b0101;
	end

	// each level held for hold cycles, complements on the inverted lines
	task automatic put(input logic a, input logic b, input int hold);
		pins <= {a, ~a, b, ~b};
		repeat (hold) @(posedge mclk);
	endtask

	// quadrature pair, a leads b when fwd is set
	task automatic quad(input int n, input bit fwd, input int hold);
		int p;
		for (int k = 0; k < 4 * n; k++) begin
			ph = fwd ? ph + 1 : ph - 1;
			p = ph & 3;
			put(p == 1 || p == 2, p >= 2, hold);
		end
	endtask

	// pulses on a while b stays at the direction level
	task automatic cdir(input int n, input bit b, input int hold);
		// direction level settles before the first pulse
		put(1'b0, b, hold);
		for (int k = 0; k < n; k++) begin
			put(1'b1, b, hold);
			put(1'b0, b, hold);
		end
	endtask
endmodule

// ### rtl/dual_encoder_count_front_end.sv
// two-channel encoder decode, scaling and counting with register port
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`include "enc_map.svh"

// Overview of operation
// (RULE1) type 0 or 1 decodes a/b as quadrature, differential or single
// (RULE2) type 2 or 3 counts pulses on a, direction from b level
// (RULE3) sensor holds b steady for direction, a carries pulses
// (RULE4) resolution 0/1/2 gives one, two or four counts per cycle; with type 2 or 3, resolution 2 gives two counts per pulse
// (RULE5) sense 0 counts up when a leads b, sense 1 counts down
// (RULE6) impulses scaled by fractional factor 0.00001 to 9.99999
// (RULE7) every impulse added as many times as multiplier 1 to 99
// (RULE8) round-loop zero counts unlimited, else wraps within 0 to n
// (RULE9) second channel has the same independent settings as first
// (RULE10) retention 0 clears counts at power return, 1 keeps them
// (RULE11) preset command loads each channel's own preset value
// (RULE12) inputs synchronised first, scaling remainders carried forward
// (RULE13) counting down below zero in round-loop continues from n
module dual_encoder_count_front_end
	import enc_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// register port
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wr_data,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic [31:0]      rd_data,
	// encoder pins: a, /a, b, /b per channel
	input  wire logic [3:0]  enc1_pins,
	input  wire logic [3:0]  enc2_pins,
	// control inputs
	input  wire logic [1:0]  ext_preset,
	input  wire logic        power_restore,
	// counter values
	output logic [31:0]      count1,
	output logic [31:0]      count2
);
	import enc_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		chan_t [1:0] ch;
		logic [1:0]  filter;
		logic        retain;
		logic [31:0] rd_data;
	} top_state_t;

	top_state_t s;
	top_state_t next_s;
	logic [1:0] preset_hit;
	logic [1:0] clear_scale;
	logic [1:0] cnt_step;
	logic [1:0] cnt_up;

	// ---------------------------------------------------------------
	// datapath per channel
	// ---------------------------------------------------------------
	enc_step_if dec_link[2] ();
	enc_step_if cnt_link[2] ();

	enc_decode u_dec1 (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.sig_type (s.ch[0].sig_type),
		.edge_res (s.ch[0].edge_res),
		.sense    (s.ch[0].sense),
		.pins     (enc1_pins),
		.out      (dec_link[0])
	);

	enc_decode u_dec2 (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.sig_type (s.ch[1].sig_type),
		.edge_res (s.ch[1].edge_res),
		.sense    (s.ch[1].sense),
		.pins     (enc2_pins),
		.out      (dec_link[1])
	);                                                      // [RULE9]

	enc_scale u_scl1 (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.scale    (s.ch[0].scale),
		.repeat_f (s.ch[0].repeat_f),
		.clear    (clear_scale[0]),
		.din      (dec_link[0]),
		.dout     (cnt_link[0])
	);

	enc_scale u_scl2 (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.scale    (s.ch[1].scale),
		.repeat_f (s.ch[1].repeat_f),
		.clear    (clear_scale[1]),
		.din      (dec_link[1]),
		.dout     (cnt_link[1])
	);

	assign cnt_step[0] = cnt_link[0].step;
	assign cnt_step[1] = cnt_link[1].step;
	assign cnt_up[0]   = cnt_link[0].up;
	assign cnt_up[1]   = cnt_link[1].up;

	// ---------------------------------------------------------------
	// preset and power-return clearing
	// ---------------------------------------------------------------
	always_comb begin
		preset_hit = ext_preset;
		if (wr_en && addr[7:4] == `GRP_GLOBAL
		    && addr[3:0] == `FLD_COMMAND) begin
			preset_hit[0] = ext_preset[0] | wr_data[`CMD_PRESET1_BIT];
			preset_hit[1] = ext_preset[1] | wr_data[`CMD_PRESET2_BIT];
		end
		clear_scale = preset_hit | {2{power_restore & ~s.retain}};
	end

	// ---------------------------------------------------------------
	// counter step with optional round-loop
	// ---------------------------------------------------------------
	function automatic logic signed [31:0] bump(
		input logic signed [31:0] cnt,
		input logic               up,
		input logic [31:0]        wrap
	);
		logic signed [31:0] lim;
		lim = $signed(wrap);
		if (wrap == 32'h0000_0000) begin
			bump = up ? cnt + 32'sh1 : cnt - 32'sh1;        // [RULE8]
		end else if (up) begin
			bump = (cnt >= lim) ? 32'sh0 : cnt + 32'sh1;    // [RULE8]
		end else begin
			bump = (cnt <= 32'sh0) ? lim : cnt - 32'sh1;    // [RULE13]
		end
	endfunction

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic [3:0] grp;
		grp            = 4'h0;
		next_s         = s;
		next_s.rd_data = 32'h0000_0000;
		for (int i = 0; i < 2; i++) begin
			if (cnt_step[i]) begin
				next_s.ch[i].count = bump(s.ch[i].count, cnt_up[i],
				                          s.ch[i].wrap);    // [RULE9]
			end
			if (power_restore && !s.retain) begin
				next_s.ch[i].count = 32'sh0;                 // [RULE10]
			end
			if (preset_hit[i]) begin
				next_s.ch[i].count = s.ch[i].preset;         // [RULE11]
			end
		end

		// register writes
		if (wr_en) begin
			for (int i = 0; i < 2; i++) begin
				grp = (i == 0) ? `GRP_CH1 : `GRP_CH2;
				if (addr[7:4] == grp) begin
					case (addr[3:0])
						`FLD_SIGNAL_TYPE: next_s.ch[i].sig_type = wr_data[1:0];
						`FLD_EDGE_RES:    next_s.ch[i].edge_res = wr_data[1:0];
						`FLD_COUNT_SENSE: next_s.ch[i].sense    = wr_data[0];
						`FLD_SCALE:       next_s.ch[i].scale    = wr_data;
						`FLD_REPEAT:      next_s.ch[i].repeat_f = wr_data[7:0];
						`FLD_WRAP:        next_s.ch[i].wrap     = wr_data;
						`FLD_PRESET:      next_s.ch[i].preset   = wr_data;
						default: ;
					endcase
				end
			end
			if (addr[7:4] == `GRP_GLOBAL) begin
				case (addr[3:0])
					`FLD_FILTER:    next_s.filter = wr_data[1:0];
					`FLD_RETENTION: next_s.retain = wr_data[0];
					default: ;
				endcase
			end
		end

		// register reads: data stand in the following cycle
		if (rd_en) begin
			for (int i = 0; i < 2; i++) begin
				grp = (i == 0) ? `GRP_CH1 : `GRP_CH2;
				if (addr[7:4] == grp) begin
					case (addr[3:0])
						`FLD_SIGNAL_TYPE:
							next_s.rd_data = {30'h0, s.ch[i].sig_type};
						`FLD_EDGE_RES:
							next_s.rd_data = {30'h0, s.ch[i].edge_res};
						`FLD_COUNT_SENSE:
							next_s.rd_data = {31'h0, s.ch[i].sense};
						`FLD_SCALE:
							next_s.rd_data = s.ch[i].scale;
						`FLD_REPEAT:
							next_s.rd_data = {24'h0, s.ch[i].repeat_f};
						`FLD_WRAP:
							next_s.rd_data = s.ch[i].wrap;
						`FLD_PRESET:
							next_s.rd_data = s.ch[i].preset;
						`FLD_COUNT:
							next_s.rd_data = s.ch[i].count;
						default:
							next_s.rd_data = 32'h0000_0000;
					endcase
				end
			end
			if (addr[7:4] == `GRP_GLOBAL) begin
				case (addr[3:0])
					`FLD_FILTER:    next_s.rd_data = {30'h0, s.filter};
					`FLD_RETENTION: next_s.rd_data = {31'h0, s.retain};
					default:        next_s.rd_data = 32'h0000_0000;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < 2; i++) begin
				s.ch[i].sig_type <= `RST_SIGNAL_TYPE;        // [RULE1]
				s.ch[i].edge_res <= `RST_EDGE_RES;           // [RULE4]
				s.ch[i].sense    <= `RST_COUNT_SENSE;        // [RULE5]
				s.ch[i].scale    <= `RST_SCALE;              // [RULE6]
				s.ch[i].repeat_f <= `RST_REPEAT;             // [RULE7]
				s.ch[i].wrap     <= `RST_WRAP;               // [RULE8]
				s.ch[i].preset   <= `RST_PRESET;             // [RULE11]
				s.ch[i].count    <= 32'sh0;
			end
			s.filter  <= `RST_FILTER;
			s.retain  <= `RST_RETENTION;                     // [RULE10]
			s.rd_data <= 32'h0000_0000;
		end else begin
			s <= next_s;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign rd_data = s.rd_data;
	assign count1  = s.ch[0].count;
	assign count2  = s.ch[1].count;
endmodule

// ### rtl/enc_decode.sv
// input synchroniser and a/b edge decoder for one channel
module enc_decode
	import enc_pkg::*;
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	// configuration
	input  wire logic [1:0] sig_type,
	input  wire logic [1:0] edge_res,
	input  wire logic       sense,
	// encoder pins: a, /a, b, /b
	input  wire logic [3:0] pins,
	// decoded impulses
	enc_step_if.src         out
);
	typedef struct packed {
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic       a_prev;
		logic       b_prev;
		logic       step;
		logic       up;
	} dec_state_t;

	dec_state_t s;
	dec_state_t next_s;
	logic       a_lvl;
	logic       b_lvl;
	logic       a_edge;
	logic       b_edge;
	logic       use_edge;
	logic       fwd;

	always_comb begin
		next_s       = s;
		next_s.sync1 = pins;
		next_s.sync2 = s.sync1;                              // [RULE12]
		// differential receivers see a high level when a > /a
		if (sig_type == SIG_QUAD_DIFF || sig_type == SIG_CDIR_DIFF) begin
			a_lvl = s.sync2[3] & ~s.sync2[2];
			b_lvl = s.sync2[1] & ~s.sync2[0];
		end else begin
			a_lvl = s.sync2[3];
			b_lvl = s.sync2[1];
		end
		next_s.a_prev = a_lvl;
		next_s.b_prev = b_lvl;
		a_edge = a_lvl ^ s.a_prev;
		b_edge = b_lvl ^ s.b_prev;
		use_edge = 1'b0;
		fwd      = 1'b0;
		if (sig_type[1]) begin
			// count on a, static direction on b (low = forward)
			fwd = ~b_lvl;                                    // [RULE2]
			case (edge_res)
				RES_X1:  use_edge = a_edge & a_lvl;          // [RULE4]
				default: use_edge = a_edge;
			endcase
		end else begin
			case (edge_res)
				RES_X1: begin
					use_edge = a_edge & a_lvl;               // [RULE1] [RULE4]
					fwd      = ~b_lvl;
				end
				RES_X2: begin
					use_edge = a_edge;                       // [RULE4]
					fwd      = a_lvl ^ b_lvl;
				end
				default: begin
					use_edge = a_edge | b_edge;              // [RULE4]
					fwd      = a_edge ? (a_lvl ^ b_lvl) : (a_lvl ~^ b_lvl);
				end
			endcase
		end
		next_s.step = use_edge;
		next_s.up   = fwd ^ sense;                           // [RULE5]
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign out.step = s.step;
	assign out.up   = s.up;
endmodule

// ### rtl/enc_map.svh
// register offsets, field positions, reset values and scaling constants
`ifndef ENC_MAP_SVH
`define ENC_MAP_SVH

// ---------------------------------------------------------------
// address split: bits [7:4] pick the group, bits [3:0] the field
// ---------------------------------------------------------------
`define GRP_CH1           4'h0
`define GRP_CH2           4'h1
`define GRP_GLOBAL        4'h2

// ---------------------------------------------------------------
// per-channel field offsets
// ---------------------------------------------------------------
`define FLD_SIGNAL_TYPE   4'h0
`define FLD_EDGE_RES      4'h1
`define FLD_COUNT_SENSE   4'h2
`define FLD_SCALE         4'h3
`define FLD_REPEAT        4'h4
`define FLD_WRAP          4'h5
`define FLD_PRESET        4'h6
`define FLD_COUNT         4'h7

// ---------------------------------------------------------------
// global field offsets
// ---------------------------------------------------------------
`define FLD_FILTER        4'h0
`define FLD_RETENTION     4'h1
`define FLD_COMMAND       4'h2

// ---------------------------------------------------------------
// command register bit positions
// ---------------------------------------------------------------
`define CMD_PRESET1_BIT   0
`define CMD_PRESET2_BIT   1

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_SIGNAL_TYPE   2'h1
`define RST_EDGE_RES      2'h0
`define RST_COUNT_SENSE   1'h0
`define RST_SCALE         32'h000186a0
`define RST_REPEAT        8'h01
`define RST_WRAP          32'h00000000
`define RST_PRESET        32'h00000000
`define RST_FILTER        2'h0
`define RST_RETENTION     1'h0

// ---------------------------------------------------------------
// scaling: factor is held in units of 0.00001, one count = 1.00000
// ---------------------------------------------------------------
`define SCALE_ONE         32'sh000186a0
`define WRAP_MAX          32'h000f423f

`endif

// ### rtl/enc_pkg.sv
// types shared by the encoder front end
package enc_pkg;

	typedef enum logic [1:0] {
		SIG_QUAD_DIFF = 2'b00,
		SIG_QUAD_SE   = 2'b01,
		SIG_CDIR_DIFF = 2'b10,
		SIG_CDIR_SE   = 2'b11
	} sig_type_t;

	typedef enum logic [1:0] {
		RES_X1  = 2'b00,
		RES_X2  = 2'b01,
		RES_X4  = 2'b10,
		RES_RSV = 2'b11
	} edge_res_t;

	typedef struct packed {
		logic [1:0]         sig_type;
		logic [1:0]         edge_res;
		logic               sense;
		logic [31:0]        scale;
		logic [7:0]         repeat_f;
		logic [31:0]        wrap;
		logic signed [31:0] preset;
		logic signed [31:0] count;
	} chan_t;

endpackage

// ### rtl/enc_scale.sv
// repeat and fractional scaling of decoded impulses
`include "enc_map.svh"

module enc_scale (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// configuration
	input  wire logic [31:0] scale,
	input  wire logic [7:0]  repeat_f,
	input  wire logic        clear,
	// decoded impulses in, counts out
	enc_step_if.dst          din,
	enc_step_if.src          dout
);
	typedef struct packed {
		logic signed [31:0] residue;
		logic signed [15:0] pending;
		logic [7:0]         reps_left;
		logic               rep_up;
		logic               step;
		logic               up;
	} scl_state_t;

	scl_state_t         s;
	scl_state_t         next_s;
	logic signed [15:0] pend_in;
	logic [7:0]         reps;

	always_comb begin
		next_s      = s;
		next_s.step = 1'b0;
		reps        = (repeat_f == 8'h00) ? 8'h01 : repeat_f;
		pend_in     = s.pending;
		if (din.step) begin
			pend_in = din.up ? s.pending + 16'sh0001
			                 : s.pending - 16'sh0001;
		end
		// whole counts leave first, then the next repeat adds a fraction
		if (s.residue >= `SCALE_ONE) begin
			next_s.residue = s.residue - `SCALE_ONE;         // [RULE12]
			next_s.step    = 1'b1;
			next_s.up      = 1'b1;
		end else if (s.residue <= -`SCALE_ONE) begin
			next_s.residue = s.residue + `SCALE_ONE;         // [RULE12]
			next_s.step    = 1'b1;
			next_s.up      = 1'b0;
		end else if (s.reps_left != 8'h00) begin
			next_s.reps_left = s.reps_left - 8'h01;          // [RULE7]
			next_s.residue   = s.rep_up ? s.residue + $signed(scale)
			                            : s.residue - $signed(scale); // [RULE6]
		end else if (pend_in != 16'sh0000) begin
			next_s.reps_left = reps;                         // [RULE7]
			next_s.rep_up    = ~pend_in[15];
			pend_in = pend_in[15] ? pend_in + 16'sh0001
			                      : pend_in - 16'sh0001;
		end
		next_s.pending = pend_in;
		if (clear) begin
			next_s.residue   = '0;
			next_s.pending   = '0;
			next_s.reps_left = '0;
			next_s.step      = 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign dout.step = s.step;
	assign dout.up   = s.up;
endmodule

// ### rtl/enc_step_if.sv
// one-cycle count impulse with its direction
interface enc_step_if;
	logic step;
	logic up;
	modport src (output step, output up);
	modport dst (input step, input up);
endinterface
